// File: bench/tb_ufr_port.sv
// self-checking bench for the serial port registers and line paths
`timescale 1ns/1ps
module tb_ufr_port;
   logic ref_clk, resetn, reg_wr, reg_rd, rxd, txd, dtr_n, rts_n, irq, irq_oe;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, queue_control_shadow, v, b;
   int errors = 0, compares = 0, seed = 6900, n;
   logic [7:0] tx_exp[$];
   ufr_port u_dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .queue_control_shadow(queue_control_shadow), .txd(txd), .rxd(rxd), .cts_n(1'b1),
      .dsr_n(1'b1), .ri_n(1'b1), .dcd_n(1'b1), .dtr_n(dtr_n), .rts_n(rts_n), .irq(irq),
      .irq_oe(irq_oe));
   ufr_peer u_peer (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   task automatic check(input string s, input logic [7:0] seen, input logic [7:0] e);
      compares++;
      if (seen !== e)
      begin
         errors++;
         $display("unexpected %s expected %h seen %h", s, e, seen);
      end
   endtask
   task automatic tally_and_finish;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // a wait that ran out its bound ends the run as a mismatch
   task automatic bound(input int lim);
      if (n >= lim)
      begin
         errors++;
         tally_and_finish;
      end
   endtask
   // one-cycle strobes, inputs moved 2 ns after the edge
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #2 reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge ref_clk);
      #2 reg_wr = 1'b0;
   endtask
   task automatic rchk(input string s, input logic [2:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      #2 reg_addr = a;
      reg_rd = 1'b1;
      @(posedge ref_clk);
      #2 reg_rd = 1'b0;
      check(s, reg_rdata, e);
   endtask
   task automatic rx_char;
      b = $random(seed);
      u_peer.send(b);
      for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge ref_clk);
      bound(200);
   endtask
   initial
   begin
      {resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      repeat (12) @(posedge ref_clk);
      #2 resetn = 1'b1;
      rchk("ident", 3'h2, 8'h01);
      wr(3'h1, 8'hff);
      rchk("enables", 3'h1, 8'h0f);
      rchk("ident", 3'h2, 8'h02);
      rchk("ident", 3'h2, 8'h01);
      wr(3'h1, 8'h00);
      wr(3'h3, 8'h83);
      wr(3'h0, 8'h34);
      wr(3'h1, 8'h12);
      rchk("div low", 3'h0, 8'h34);
      rchk("div high", 3'h1, 8'h12);
      wr(3'h0, 8'h01);
      wr(3'h1, 8'h00);
      wr(3'h3, 8'h03);
      rchk("enables", 3'h1, 8'h00);
      v = $random(seed);
      wr(3'h7, v);
      rchk("scratch", 3'h7, v);
      wr(3'h2, 8'h0f);
      check("shadow", queue_control_shadow, 8'h0f);
      rchk("ident", 3'h2, 8'hc1);
      $display("register test done");
      // back-to-back writes: second waits for the shifter to finish the first
      repeat (2)
      begin
         v = $random(seed);
         tx_exp.push_back(v);
         wr(3'h0, v);
      end
      for (n = 0; n < 2000 && u_peer.got_q.size() < 2; n++) @(posedge ref_clk);
      bound(2000);
      foreach (tx_exp[i]) check("tx byte", u_peer.got_q[i], tx_exp[i]);
      $display("transmit test done");
      wr(3'h1, 8'h01);
      wr(3'h4, 8'h0b);
      rx_char();
      check("irq", {7'h0, irq & irq_oe}, 8'h01);
      check("dtr rts", {6'h0, dtr_n, rts_n}, 8'h00);
      rchk("ident", 3'h2, 8'hc4);
      rchk("rx byte", 3'h0, b);
      rchk("ident", 3'h2, 8'hc1);
      rx_char();
      wr(3'h2, 8'h03);
      rchk("ident", 3'h2, 8'hc1);
      wr(3'h4, 8'h00);
      // the enable pin follows one edge late; look after that edge has settled
      @(posedge ref_clk);
      #2 check("irq oe", {7'h0, irq_oe}, 8'h00);
      check("dtr rts", {6'h0, dtr_n, rts_n}, 8'h03);
      $display("receive test done");
      tally_and_finish;
   end
endmodule

// File: bench/ufr_peer.sv
// serial line peer: frames bytes onto rxd and collects bytes from txd
`timescale 1ns/1ps
module ufr_peer #(
   parameter int BIT_CLKS = 16
) (
   // clock
   input wire logic ref_clk,
   // serial line
   input wire logic txd,
   output logic rxd
);
   logic [7:0] got_q[$];
   initial rxd = 1'b1;
   // sample mid bit after the start edge; 8n1 only, parity frames are not decoded
   initial
   begin
      logic [7:0] b;
      forever
      begin
         @(negedge txd);
         repeat (BIT_CLKS / 2) @(posedge ref_clk);
         for (int i = 0; i < 8; i++)
         begin
            repeat (BIT_CLKS) @(posedge ref_clk);
            b[i] = txd;
         end
         repeat (BIT_CLKS) @(posedge ref_clk);
         got_q.push_back(b);
      end
   end
   // start bit, data lsb first, one stop; line rests at mark level after
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         #2 rxd = f[i];
         repeat (BIT_CLKS) @(posedge ref_clk);
      end
   endtask
endmodule

// File: hdl/ufr_defines.svh
// register offsets, field positions, reset values and timing counts for the serial port
`ifndef UFR_DEFINES_SVH
`define UFR_DEFINES_SVH
`define UFR_OFS_DATA 3'h0
`define UFR_OFS_IER 3'h1
`define UFR_OFS_IIR 3'h2
`define UFR_OFS_LCR 3'h3
`define UFR_OFS_MCR 3'h4
`define UFR_OFS_LSR 3'h5
`define UFR_OFS_MSR 3'h6
`define UFR_OFS_SCR 3'h7
`define UFR_LCR_DIVISOR_LATCH_SELECT 7
`define UFR_LCR_BREAK 6
`define UFR_LCR_STICK 5
`define UFR_LCR_EVEN 4
`define UFR_LCR_PAREN 3
`define UFR_LCR_STOP 2
`define UFR_IER_RDA 0
`define UFR_IER_THRE 1
`define UFR_IER_LSI 2
`define UFR_IER_MSI 3
`define UFR_FCR_EN 0
`define UFR_FCR_RXCLR 1
`define UFR_FCR_TXCLR 2
`define UFR_MCR_INTERRUPT_OUTPUT_GATE 3
`define UFR_MCR_LOOP 4
`define UFR_RST_DIVISOR 16'h0001
`define UFR_IIR_NONE 4'h1
`define UFR_IIR_LSI 4'h6
`define UFR_IIR_RDA 4'h4
`define UFR_IIR_TMO 4'hc
`define UFR_IIR_THRE 4'h2
`define UFR_IIR_MSI 4'h0
`define UFR_TRIG_1 5'h01
`define UFR_TRIG_4 5'h04
`define UFR_TRIG_8 5'h08
`define UFR_TRIG_14 5'h0e
`define UFR_OVERSAMPLE 5'h10
`define UFR_MID_SAMPLE 5'h07
`define UFR_TIMEOUT_CHARS 4
`endif

// File: hdl/ufr_pkg.sv
// shared types of the serial port
package ufr_pkg;
   typedef enum logic [2:0] {
      ufr_idle = 3'b000,
      ufr_start = 3'b001,
      ufr_data = 3'b010,
      ufr_parity = 3'b011,
      ufr_stop = 3'b100
   } ufr_line_type;
endpackage

// File: hdl/ufr_port.sv
// compatible serial port: register set, queues, baud generator and line engines
// Operation
// - offsets 0..7 decoded; line control bit 7 maps 0 and 1 to divisor.
// - divisor select clear: offset 0 reads receive queue, writes transmit queue.
// - characters go out and come in least significant bit first.
// - receiver shifts bits hidden, then moves whole word into holding queue.
// - transmit shifter reloads only after previous character fully sent.
// - enable bit 0 gates data available and character timeout interrupts.
// - enable bit 1 gates transmit holding empty interrupt.
// - enable bit 2 gates line status interrupt for overrun, parity, framing, break.
// - enable bit 3 gates interrupt on any modem status change flag.
// - enable register bits 4 to 7 always read zero.
// - all enables clear means no interrupt and ident shows none pending.
// - interrupt output driven only while output-two bit is one.
// - offset 2 writes queue control always; reads return interrupt ident.
// - control bit 0 enables both queues; clearing it empties and disables them.
// - control bit 1 empties receive queue, keeps shifter, acts in the write cycle only.
// - control bit 2 empties transmit queue, keeps shifter, acts in the write cycle only.
// - control bit 3 has no effect.
// - control bits 6 and 7 pick receive interrupt fill level.
// - last written queue control value readable from a shadow copy.
// - baud generator divides clock by 16-bit divisor, 1 to 65535.
// - one start bit, 1, 1.5 or 2 stops, even, odd, stick or no parity.
// - fill level codes 0 to 3 mean 1, 4, 8 and 14 bytes.
// - line status over data or timeout over transmit empty over modem.
`timescale 1ns/1ps
`include "ufr_defines.svh"
module ufr_port #(
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic [7:0] queue_control_shadow,
   // serial line and modem pins
   output logic txd,
   input wire logic rxd,
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic ri_n,
   input wire logic dcd_n,
   output logic dtr_n,
   output logic rts_n,
   // interrupt pin, driven while irq_oe is high
   output logic irq,
   output logic irq_oe
);
   ufr_queue_if #(.WIDTH(8), .DEPTH(DEPTH)) txq ();
   ufr_queue_if #(.WIDTH(11), .DEPTH(DEPTH)) rxq ();
   ufr_queue #(.WIDTH(8), .DEPTH(DEPTH)) u_txq (.ref_clk(ref_clk), .resetn(resetn), .q(txq));
   ufr_queue #(.WIDTH(11), .DEPTH(DEPTH)) u_rxq (.ref_clk(ref_clk), .resetn(resetn), .q(rxq));

   logic [7:0] lcr, mcr, scr;
   logic [3:0] interrupt_enables;
   logic [15:0] divisor, div_cnt;
   logic fifo_en;
   logic [1:0] trig_sel;
   logic oe, pe, fe, bi, thre_pend;
   logic [3:0] msr_now, msr_delta;
   logic tick;
   ufr_pkg::ufr_line_type tx_state, rx_state;
   logic [4:0] tx_tck, rx_tck;
   logic [2:0] tx_bit, rx_bit;
   logic [7:0] tx_shift, rx_shift;
   logic tx_line, rx_zero, rx_perr;
   logic [9:0] to_cnt;
   logic wr_data, rd_data, wr_fcr, rd_iir, rd_lsr, rd_msr, divisor_latch_select, loop, rx_in;
   logic [2:0] wl_last;
   logic rda, tmo, lsi_p, rdi_p, thri_p, msi_p;
   logic [3:0] iir_code;
   logic [3:0] modem_in;

   // true parity bit for the selected mode, shared by transmitter and receiver
   function automatic logic ufr_par_bit(input logic [7:0] d, input logic [7:0] ctl);
      logic [7:0] m;
      m = d & (8'hff >> (3'h3 - {1'b0, ctl[1:0]}));
      if (ctl[`UFR_LCR_STICK])
         return !ctl[`UFR_LCR_EVEN];
      return ctl[`UFR_LCR_EVEN] ? ^m : ~^m;
   endfunction

   // receive fill level that raises the data interrupt
   function automatic logic [4:0] ufr_trig(input logic [1:0] sel);
      unique case (sel)
         2'h0: return `UFR_TRIG_1;
         2'h1: return `UFR_TRIG_4;
         2'h2: return `UFR_TRIG_8;
         2'h3: return `UFR_TRIG_14;
      endcase
   endfunction

   // address decode with divisor select
   assign divisor_latch_select = lcr[`UFR_LCR_DIVISOR_LATCH_SELECT];
   assign loop = mcr[`UFR_MCR_LOOP];
   assign wl_last = 3'h4 + {1'b0, lcr[1:0]};
   assign wr_data = reg_wr && reg_addr == `UFR_OFS_DATA && !divisor_latch_select;
   assign rd_data = reg_rd && reg_addr == `UFR_OFS_DATA && !divisor_latch_select;
   assign wr_fcr = reg_wr && reg_addr == `UFR_OFS_IIR;
   assign rd_iir = reg_rd && reg_addr == `UFR_OFS_IIR;
   assign rd_lsr = reg_rd && reg_addr == `UFR_OFS_LSR;
   assign rd_msr = reg_rd && reg_addr == `UFR_OFS_MSR;

   // writable registers; reserved enable bits are never stored
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         lcr <= 8'h00;
         mcr <= 8'h00;
         scr <= 8'h00;
         interrupt_enables <= 4'h0;
         divisor <= `UFR_RST_DIVISOR;
      end
      else if (reg_wr)
      begin
         unique case (reg_addr)
            `UFR_OFS_DATA: if (divisor_latch_select) divisor[7:0] <= reg_wdata;
            `UFR_OFS_IER:
               if (divisor_latch_select)
                  divisor[15:8] <= reg_wdata;
               else
                  interrupt_enables <= reg_wdata[3:0];
            `UFR_OFS_LCR: lcr <= reg_wdata;
            `UFR_OFS_MCR: mcr <= {3'h0, reg_wdata[4:0]};
            `UFR_OFS_SCR: scr <= reg_wdata;
            default: ;
         endcase
      end
   end

   // queue control: bits 1, 2, 6, 7 taken only with bit 0 set, bit 3 ignored
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         fifo_en <= 1'b0;
         trig_sel <= 2'h0;
         queue_control_shadow <= 8'h00;
      end
      else if (wr_fcr)
      begin
         queue_control_shadow <= reg_wdata;
         fifo_en <= reg_wdata[`UFR_FCR_EN];
         if (reg_wdata[`UFR_FCR_EN])
            trig_sel <= reg_wdata[7:6];
      end
   end

   // flushes are single pulses; the clear bits stay set only in the shadow copy
   assign rxq.flush = wr_fcr && (!reg_wdata[`UFR_FCR_EN] || !fifo_en ||
                      reg_wdata[`UFR_FCR_RXCLR]);
   assign txq.flush = wr_fcr && (!reg_wdata[`UFR_FCR_EN] || !fifo_en ||
                      reg_wdata[`UFR_FCR_TXCLR]);

   // without the queues enabled each side holds a single character
   assign txq.push = wr_data && (fifo_en ? !txq.full : txq.empty);
   assign txq.push_data = reg_wdata;
   assign rxq.pop = rd_data;

   // baud tick: one pulse every divisor clocks, a zero divisor acts as one
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         div_cnt <= 16'h0001;
      else if (div_cnt <= 16'h0001)
         div_cnt <= divisor;
      else
         div_cnt <= div_cnt - 16'h0001;
   end
   assign tick = (div_cnt <= 16'h0001);

   // transmit engine, sixteen ticks per bit
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_state <= ufr_pkg::ufr_idle;
         tx_tck <= 5'h00;
         tx_bit <= 3'h0;
         tx_shift <= 8'h00;
         tx_line <= 1'b1;
      end
      else if (tx_state == ufr_pkg::ufr_idle)
      begin
         if (!txq.empty && tick)
         begin
            tx_shift <= txq.head;
            tx_state <= ufr_pkg::ufr_start;
            tx_line <= 1'b0;
            tx_tck <= 5'h00;
            tx_bit <= 3'h0;
         end
      end
      else if (tick)
      begin
         tx_tck <= tx_tck + 5'h01;
         unique case (tx_state)
            ufr_pkg::ufr_start, ufr_pkg::ufr_data:
               if (tx_tck == `UFR_OVERSAMPLE - 5'h01)
               begin
                  tx_tck <= 5'h00;
                  if (tx_state == ufr_pkg::ufr_start)
                  begin
                     tx_state <= ufr_pkg::ufr_data;
                     tx_line <= tx_shift[0];
                  end
                  else if (tx_bit != wl_last)
                  begin
                     tx_bit <= tx_bit + 3'h1;
                     tx_line <= tx_shift[tx_bit + 3'h1];
                  end
                  else if (lcr[`UFR_LCR_PAREN])
                  begin
                     tx_state <= ufr_pkg::ufr_parity;
                     tx_line <= ufr_par_bit(tx_shift, lcr);
                  end
                  else
                  begin
                     tx_state <= ufr_pkg::ufr_stop;
                     tx_line <= 1'b1;
                  end
               end
            ufr_pkg::ufr_parity:
               if (tx_tck == `UFR_OVERSAMPLE - 5'h01)
               begin
                  tx_tck <= 5'h00;
                  tx_state <= ufr_pkg::ufr_stop;
                  tx_line <= 1'b1;
               end
            ufr_pkg::ufr_stop:
               // 1, 1.5 or 2 stop bits measured in ticks
               if ({1'b0, tx_tck} == (!lcr[`UFR_LCR_STOP] ? 6'h0f :
                   (lcr[1:0] == 2'h0 ? 6'h17 : 6'h1f)))
                  tx_state <= ufr_pkg::ufr_idle;
            default: tx_state <= ufr_pkg::ufr_idle;
         endcase
      end
   end
   assign txq.pop = (tx_state == ufr_pkg::ufr_idle) && !txq.empty && tick;

   // receive engine, samples mid bit; only the first stop bit is checked
   assign rx_in = loop ? tx_line : rxd;
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_state <= ufr_pkg::ufr_idle;
         rx_tck <= 5'h00;
         rx_bit <= 3'h0;
         rx_shift <= 8'h00;
         rx_zero <= 1'b0;
         rx_perr <= 1'b0;
      end
      else if (tick)
      begin
         rx_tck <= rx_tck + 5'h01;
         unique case (rx_state)
            ufr_pkg::ufr_idle:
               if (!rx_in)
               begin
                  rx_state <= ufr_pkg::ufr_start;
                  rx_tck <= 5'h00;
               end
            ufr_pkg::ufr_start:
               if (rx_tck == `UFR_MID_SAMPLE)
               begin
                  rx_state <= rx_in ? ufr_pkg::ufr_idle : ufr_pkg::ufr_data;
                  rx_tck <= 5'h00;
                  rx_bit <= 3'h0;
                  rx_shift <= 8'h00;
                  rx_zero <= 1'b1;
                  rx_perr <= 1'b0;
               end
            ufr_pkg::ufr_data, ufr_pkg::ufr_parity:
               if (rx_tck == `UFR_OVERSAMPLE - 5'h01)
               begin
                  rx_tck <= 5'h00;
                  rx_zero <= rx_zero && !rx_in;
                  if (rx_state == ufr_pkg::ufr_parity)
                  begin
                     rx_perr <= (rx_in != ufr_par_bit(rx_shift, lcr));
                     rx_state <= ufr_pkg::ufr_stop;
                  end
                  else
                  begin
                     rx_shift[rx_bit] <= rx_in;
                     rx_bit <= rx_bit + 3'h1;
                     if (rx_bit == wl_last)
                        rx_state <= lcr[`UFR_LCR_PAREN] ? ufr_pkg::ufr_parity :
                                    ufr_pkg::ufr_stop;
                  end
               end
            ufr_pkg::ufr_stop:
               if (rx_tck == `UFR_OVERSAMPLE - 5'h01)
                  rx_state <= ufr_pkg::ufr_idle;
            default: rx_state <= ufr_pkg::ufr_idle;
         endcase
      end
   end

   // completed word with its error flags: {break, framing, parity, data}
   logic rx_done, rx_room;
   assign rx_done = tick && rx_state == ufr_pkg::ufr_stop && rx_tck == `UFR_OVERSAMPLE - 5'h01;
   assign rx_room = fifo_en ? !rxq.full : rxq.empty;
   assign rxq.push = rx_done && rx_room;
   assign rxq.push_data = {rx_zero && !rx_in, !rx_in, rx_perr, rx_shift};

   // line status flags; a new error in the read cycle survives the read
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         oe <= 1'b0;
         pe <= 1'b0;
         fe <= 1'b0;
         bi <= 1'b0;
      end
      else
      begin
         oe <= (rx_done && !rx_room) || (oe && !rd_lsr);
         pe <= (rxq.push && rxq.push_data[8]) || (pe && !rd_lsr);
         fe <= (rxq.push && rxq.push_data[9]) || (fe && !rd_lsr);
         bi <= (rxq.push && rxq.push_data[10]) || (bi && !rd_lsr);
      end
   end

   // character timeout: four character times without queue traffic
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         to_cnt <= 10'h000;
      else if (rxq.push || rxq.pop || rxq.empty || !fifo_en)
         to_cnt <= 10'h000;
      else if (tick && !tmo)
         to_cnt <= to_cnt + 10'h001;
   end
   assign tmo = fifo_en && !rxq.empty &&
                to_cnt >= 10'(`UFR_TIMEOUT_CHARS * 16 * (3 + wl_last + lcr[`UFR_LCR_PAREN]));
   assign rda = fifo_en ? (rxq.count >= ufr_trig(trig_sel)) : !rxq.empty;

   // modem inputs, looped from the control bits in diagnostic mode
   assign modem_in = loop ? {mcr[3], mcr[2], mcr[0], mcr[1]} : {!dcd_n, !ri_n, !dsr_n, !cts_n};
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         msr_now <= 4'h0;
         msr_delta <= 4'h0;
      end
      else
      begin
         msr_now <= modem_in;
         msr_delta <= {msr_now[3] ^ modem_in[3], msr_now[2] && !modem_in[2],
                       msr_now[1:0] ^ modem_in[1:0]} | (rd_msr ? 4'h0 : msr_delta);
      end
   end

   // holding empty pending: set when the queue drains or the enable rises
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         thre_pend <= 1'b0;
      else if ((txq.pop && txq.count == 1) || txq.flush ||
               (reg_wr && reg_addr == `UFR_OFS_IER && !divisor_latch_select && reg_wdata[1] && txq.empty))
         thre_pend <= 1'b1;
      else if (wr_data || (rd_iir && iir_code == `UFR_IIR_THRE))
         thre_pend <= 1'b0;
   end

   // prioritised identification
   assign lsi_p = interrupt_enables[`UFR_IER_LSI] && (oe || pe || fe || bi);
   assign rdi_p = interrupt_enables[`UFR_IER_RDA] && (rda || tmo);
   assign thri_p = interrupt_enables[`UFR_IER_THRE] && thre_pend;
   assign msi_p = interrupt_enables[`UFR_IER_MSI] && |msr_delta;
   always_comb
   begin
      if (lsi_p)
         iir_code = `UFR_IIR_LSI;
      else if (rdi_p)
         iir_code = (rda || !tmo) ? `UFR_IIR_RDA : `UFR_IIR_TMO;
      else if (thri_p)
         iir_code = `UFR_IIR_THRE;
      else if (msi_p)
         iir_code = `UFR_IIR_MSI;
      else
         iir_code = `UFR_IIR_NONE;
   end

   // read data is registered, one cycle after the strobe
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         reg_rdata <= 8'h00;
      else if (reg_rd)
      begin
         unique case (reg_addr)
            `UFR_OFS_DATA: reg_rdata <= divisor_latch_select ? divisor[7:0] : rxq.head[7:0];
            `UFR_OFS_IER: reg_rdata <= divisor_latch_select ? divisor[15:8] : {4'h0, interrupt_enables};
            `UFR_OFS_IIR: reg_rdata <= {fifo_en, fifo_en, 2'h0, iir_code};
            `UFR_OFS_LCR: reg_rdata <= lcr;
            `UFR_OFS_MCR: reg_rdata <= mcr;
            `UFR_OFS_LSR: reg_rdata <= {fifo_en && (pe || fe || bi),
               txq.empty && tx_state == ufr_pkg::ufr_idle, txq.empty, bi, fe, pe, oe,
               !rxq.empty};
            `UFR_OFS_MSR: reg_rdata <= {msr_now, msr_delta};
            `UFR_OFS_SCR: reg_rdata <= scr;
         endcase
      end
   end

   // pins from flip-flops; break forces space, loopback forces mark
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         txd <= 1'b1;
         dtr_n <= 1'b1;
         rts_n <= 1'b1;
         irq <= 1'b0;
         irq_oe <= 1'b0;
      end
      else
      begin
         txd <= lcr[`UFR_LCR_BREAK] ? 1'b0 : (loop || tx_line);
         dtr_n <= loop || !mcr[0];
         rts_n <= loop || !mcr[1];
         irq <= (iir_code != `UFR_IIR_NONE) && mcr[`UFR_MCR_INTERRUPT_OUTPUT_GATE];
         irq_oe <= mcr[`UFR_MCR_INTERRUPT_OUTPUT_GATE];
      end
   end

   // checks
   a_ier_upper_zero: assert property (@(posedge ref_clk) disable iff (!resetn)
      (reg_rd && reg_addr == `UFR_OFS_IER && !divisor_latch_select) |=> reg_rdata[7:4] == 4'h0)
      else $error("enable register upper bits not zero");
   a_quiet_no_enable: assert property (@(posedge ref_clk) disable iff (!resetn)
      (interrupt_enables == 4'h0) |-> iir_code == `UFR_IIR_NONE ##1 !irq)
      else $error("interrupt seen with all enables clear");
   a_irq_interrupt_output_gate_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
      (irq_oe || irq) |-> $past(mcr[`UFR_MCR_INTERRUPT_OUTPUT_GATE]))
      else $error("interrupt driven with output-two clear");
   a_tx_load_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
      txq.pop |-> tx_state == ufr_pkg::ufr_idle ##1 tx_state == ufr_pkg::ufr_start)
      else $error("transmit shifter loaded while busy");
   a_rx_push_stop: assert property (@(posedge ref_clk) disable iff (!resetn)
      rxq.push |-> rx_state == ufr_pkg::ufr_stop)
      else $error("receive word moved before the stop bit");
   a_rx_flush: assert property (@(posedge ref_clk) disable iff (!resetn)
      (wr_fcr && reg_wdata[1:0] == 2'h3) |=> rxq.empty)
      else $error("receive queue not emptied");
   a_tx_flush: assert property (@(posedge ref_clk) disable iff (!resetn)
      (wr_fcr && reg_wdata[2] && reg_wdata[0]) |=> txq.empty)
      else $error("transmit queue not emptied");
   a_fifo_off: assert property (@(posedge ref_clk) disable iff (!resetn)
      (wr_fcr && !reg_wdata[0]) |=> (!fifo_en && txq.empty && rxq.empty))
      else $error("queues not cleared when disabled");
   a_divisor_latch_select_no_pop: assert property (@(posedge ref_clk) disable iff (!resetn)
      (reg_rd && reg_addr == `UFR_OFS_DATA && divisor_latch_select) |-> !rxq.pop)
      else $error("divisor read popped the receive queue");
   a_lsi_first: assert property (@(posedge ref_clk) disable iff (!resetn)
      lsi_p |-> iir_code == `UFR_IIR_LSI)
      else $error("line status not ranked first");
   c_char_sent: cover property (@(posedge ref_clk) disable iff (!resetn)
      txq.pop ##[1:1000] tx_state == ufr_pkg::ufr_idle);
   c_char_recv: cover property (@(posedge ref_clk) disable iff (!resetn) rxq.push);
   c_irq_raised: cover property (@(posedge ref_clk) disable iff (!resetn) irq && irq_oe);
endmodule

// File: hdl/ufr_queue.sv
// character queue with flush, used for both transmit and receive
`timescale 1ns/1ps
module ufr_queue #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // queue side
   ufr_queue_if.queue q
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] rd_ptr;
   logic [AW-1:0] wr_ptr;
   logic do_push;
   logic do_pop;

   // push into a full queue and pop from an empty one are dropped
   assign do_push = q.push && !q.full;
   assign do_pop = q.pop && !q.empty;
   assign q.empty = (q.count == '0);
   assign q.full = (q.count == (AW+1)'(DEPTH));
   assign q.head = mem[rd_ptr];

   // storage, no reset needed since count guards every read
   always_ff @(posedge ref_clk)
   begin
      if (do_push && !q.flush)
         mem[wr_ptr] <= q.push_data;
   end

   // pointers and count; flush wins over push and pop
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         q.count <= '0;
      end
      else if (q.flush)
      begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         q.count <= '0;
      end
      else
      begin
         if (do_push)
            wr_ptr <= wr_ptr + 1'b1;
         if (do_pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (do_push && !do_pop)
            q.count <= q.count + 1'b1;
         else if (do_pop && !do_push)
            q.count <= q.count - 1'b1;
      end
   end
endmodule

// File: hdl/ufr_queue_if.sv
// connection between the port logic and one of its character queues
`timescale 1ns/1ps
interface ufr_queue_if #(parameter int WIDTH = 8, parameter int DEPTH = 16);
   logic push;
   logic [WIDTH-1:0] push_data;
   logic pop;
   logic [WIDTH-1:0] head;
   logic flush;
   logic [$clog2(DEPTH):0] count;
   logic empty;
   logic full;
   modport owner (output push, push_data, pop, flush, input head, count, empty, full);
   modport queue (input push, push_data, pop, flush, output head, count, empty, full);
endinterface
